// ===== logic/rsmr_map.vh
/*
  Register indices, field positions, reset values and mode codes
  of the radio status and miscellaneous register bank.
  Assumes inclusion by the bank module only; definitions only.
*/
`ifndef RSMR_MAP_VH
`define RSMR_MAP_VH

// Register indices, byte address is four times the index
`define RSMR_IDX_IRQ_STATUS_TWO      8'h3f
`define RSMR_IDX_PIN_ROUTING_ONE     8'h40
`define RSMR_IDX_PIN_ROUTING_TWO     8'h41
`define RSMR_IDX_CHIP_REVISION       8'h42
`define RSMR_IDX_FAST_HOP_CONTROL    8'h44
`define RSMR_IDX_REF_CLOCK_SELECT    8'h4b
`define RSMR_IDX_AMP_BOOST_OPTION    8'h4d
`define RSMR_IDX_CAL_TEMPERATURE     8'h5b
`define RSMR_IDX_BITRATE_FRACTION    8'h5d
`define RSMR_IDX_EVENT_STATUS        8'h7c
`define RSMR_IDX_EVENT_MASK          8'h7d

// Flag positions in irq_status_two
`define RSMR_BIT_QUEUE_FULL          7
`define RSMR_BIT_QUEUE_EMPTY         6
`define RSMR_BIT_QUEUE_LEVEL         5
`define RSMR_BIT_QUEUE_OVERRUN       4
`define RSMR_BIT_TX_DONE             3
`define RSMR_BIT_RX_PAYLOAD_DONE     2
`define RSMR_BIT_CHECKSUM_GOOD       1
`define RSMR_BIT_SUPPLY_LOW          0

// Other field positions
`define RSMR_BIT_ROUTING_CHOICE      0
`define RSMR_BIT_QUICK_HOP           7
`define RSMR_BIT_EXT_REFERENCE       4
`define RSMR_BOOST_MAX               3'h7

// Event status bits (interrupt register)
`define RSMR_EV_TX_DONE              0
`define RSMR_EV_PAYLOAD              1
`define RSMR_EV_CHECKSUM             2
`define RSMR_EV_OVERRUN              3
`define RSMR_EV_SUPPLY_LOW           4
`define RSMR_EV_COUNT                5

// Reset values and queue depth
`define RSMR_RST_PIN_ROUTING         8'h00
`define RSMR_RST_FAST_HOP            8'h2d
`define RSMR_RST_REF_CLOCK           8'h09
`define RSMR_RST_AMP_BOOST           8'h84
`define RSMR_RST_CAL_TEMPERATURE     8'h00
`define RSMR_RST_BITRATE_FRACTION    4'h0
`define RSMR_QUEUE_DEPTH             66

// Operating mode codes
`define RSMR_MODE_SLEEP              3'h0
`define RSMR_MODE_STANDBY            3'h1
`define RSMR_MODE_SYNTH_TX           3'h2
`define RSMR_MODE_TX                 3'h3
`define RSMR_MODE_SYNTH_RX           3'h4
`define RSMR_MODE_RX                 3'h5

`endif

// ===== logic/rsmr_regs.v
/*
  Status and miscellaneous register bank of a sub-GHz transceiver,
  an APB slave with zero-wait-state answers.
  Assumes the radio core runs on pclk and gives one-cycle strobes;
  the supply comparator output is asynchronous and synchronised here.
*/
// How it works
// - Queue-full flag high exactly while the queue holds 66 bytes.
// - Queue-empty flag high while no byte is queued.
// - Queue-level flag high only when count strictly exceeds the threshold.
// - Overrun flag set outside sleep; writing one flushes queue and all flags but supply-low.
// - Tx-done flag set at packet end in transmit, cleared on leaving transmit.
// - Payload flag set after last byte, checksum needed if checked and autoclear not disabled; clears on empty.
// - Checksum-good flag set on a verified payload; cleared when queue empties.
// - Supply-low flag sticky until software writes one to it.
// - Six two-bit pin routing fields, all resetting to zero.
// - Choice bit routes signal-strength event (0) or preamble event (1).
// - Read-only revision byte: full revision high nibble, metal revision low.
// - Quick hop applies frequency on low-byte write, else on synth mode entry.
// - Reference select bit picks crystal (0) or external clipped sine (1).
// - Boost field resets to 4; value 7 with power 1111 gives +20 dBm.
// - Readable, writable byte holds temperature of the latest calibration.
// - Four-bit rate fraction extends the bit-rate divider in FSK only.
`timescale 1ns/1ps
`include "rsmr_map.vh"

module rsmr_regs #(
  parameter       ADDR_W      = 12,
  parameter       THRESH_W    = 6,
  parameter [7:0] REV_CODE    = 8'h21  // Arbitrary value
) (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [ADDR_W-1:0]   paddr,
  input  wire [31:0]         pwdata,
  input  wire [3:0]          pstrb,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire [2:0]          op_mode,
  input  wire                queue_push,
  input  wire                queue_pop,
  input  wire [THRESH_W-1:0] queue_threshold,
  input  wire                tx_packet_end,
  input  wire                rx_last_byte,
  input  wire                rx_checksum_pass,
  input  wire                checksum_enable,
  input  wire                checksum_autoclear_disable,
  input  wire                supply_below_async,
  input  wire                rssi_event,
  input  wire                preamble_found_event,
  input  wire                carrier_freq_low_byte_wr,
  input  wire [3:0]          tx_power_setting,
  input  wire                fsk_mode,
  input  wire                cal_done,
  input  wire [7:0]          live_temperature_reading,
  output reg                 queue_flush,
  output reg  [5:0]          event_pin,
  output reg                 freq_apply,
  output reg                 external_reference_select,
  output reg  [2:0]          amplifier_boost_field,
  output reg                 boost_20dbm_active,
  output reg  [3:0]          rate_divider_fraction,
  output reg                 rate_fraction_active,
  output reg                 irq
);

  localparam [6:0] DEPTH = `RSMR_QUEUE_DEPTH;

  // Byte index of an APB address; low two bits are ignored
  function [7:0] reg_index;
    input [ADDR_W-1:0] a;
    begin
      reg_index = a[9:2];
    end
  endfunction

  // Event source for one routed pin
  function pin_source;
    input [1:0] sel;
    input       done_ev;
    input       level_ev;
    input       routed_ev;
    input       low_ev;
    begin
      case (sel)
        2'h0:    pin_source = done_ev;
        2'h1:    pin_source = level_ev;
        2'h2:    pin_source = routed_ev;
        default: pin_source = low_ev;
      endcase
    end
  endfunction

  reg  [6:0]  count_r;
  reg  [6:0]  count_nxt;
  reg         overrun_r;
  reg         tx_done_r;
  reg         payload_r;
  reg         checksum_r;
  reg         supply_low_r;
  reg         supply_meta_r;
  reg         supply_sync_r;
  reg  [7:0]  routing_one_r;
  reg  [7:0]  routing_two_r;
  reg  [7:0]  fast_hop_r;
  reg  [7:0]  ref_clock_r;
  reg  [7:0]  amp_boost_r;
  reg  [7:0]  cal_temp_r;
  reg  [3:0]  rate_frac_r;
  reg  [2:0]  mode_prev_r;
  reg  [`RSMR_EV_COUNT-1:0] ev_status_r;
  reg  [`RSMR_EV_COUNT-1:0] ev_mask_r;
  reg  [31:0] rdata;
  reg         hit;

  wire [7:0]  idx       = reg_index(paddr);
  wire        wr_go     = psel & penable & pready & pwrite & pstrb[0];
  wire        setup     = psel & ~penable;
  wire        flag_wr   = wr_go & (idx == `RSMR_IDX_IRQ_STATUS_TWO);
  wire        flush_req = flag_wr & pwdata[`RSMR_BIT_QUEUE_OVERRUN];
  wire        in_tx     = (op_mode == `RSMR_MODE_TX);
  wire        in_rx     = (op_mode == `RSMR_MODE_RX);
  wire        full      = (count_r == DEPTH);
  wire        empty     = (count_r == 7'h00);
  wire        level     = (count_r > {1'b0, queue_threshold});
  wire        do_push   = queue_push & ~full;
  wire        do_pop    = queue_pop & ~empty;
  wire        ovr_set   = queue_push & full & (op_mode != `RSMR_MODE_SLEEP);
  wire        tx_set    = tx_packet_end & in_tx;
  wire        crc_need  = checksum_enable & ~checksum_autoclear_disable;
  wire        pay_set   = rx_last_byte & in_rx & (~crc_need | rx_checksum_pass);
  wire        crc_set   = rx_last_byte & in_rx & rx_checksum_pass;
  wire        low_set   = supply_sync_r;
  wire        empty_nxt = (count_nxt == 7'h00);
  wire [7:0]  flags = {full, empty, level, overrun_r, tx_done_r,
                       payload_r, checksum_r, supply_low_r};
  wire        routed_ev = routing_two_r[`RSMR_BIT_ROUTING_CHOICE] ?
                          preamble_found_event : rssi_event;
  wire        done_ev   = in_tx ? tx_done_r : payload_r;
  wire [11:0] routing   = {routing_one_r, routing_two_r[7:4]};
  wire        synth_in  = (op_mode == `RSMR_MODE_SYNTH_TX ||
                           op_mode == `RSMR_MODE_SYNTH_RX) &&
                          (mode_prev_r != op_mode);
  wire [`RSMR_EV_COUNT-1:0] ev_set = {low_set & ~supply_low_r, ovr_set,
                                      crc_set, pay_set, tx_set};

  // Fill count; a flush empties the queue even if a byte arrives with it
  always @* begin
    count_nxt = count_r;
    if (flush_req) begin
      count_nxt = 7'h00;
    end else if (do_push & ~do_pop) begin
      count_nxt = count_r + 7'h01;
    end else if (do_pop & ~do_push) begin
      count_nxt = count_r - 7'h01;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r       <= 7'h00;
      overrun_r     <= 1'b0;
      tx_done_r     <= 1'b0;
      payload_r     <= 1'b0;
      checksum_r    <= 1'b0;
      supply_low_r  <= 1'b0;
      supply_meta_r <= 1'b0;
      supply_sync_r <= 1'b0;
      queue_flush   <= 1'b0;
    end else begin
      count_r       <= count_nxt;
      supply_meta_r <= supply_below_async;
      supply_sync_r <= supply_meta_r;
      queue_flush   <= flush_req;
      // Set wins over every clear below
      overrun_r     <= ovr_set | (overrun_r & ~flush_req);
      tx_done_r     <= tx_set | (tx_done_r & in_tx & ~flush_req);
      payload_r     <= pay_set | (payload_r & ~empty_nxt);
      checksum_r    <= crc_set | (checksum_r & ~empty_nxt);
      supply_low_r  <= low_set |
                       (supply_low_r & ~(flag_wr & pwdata[`RSMR_BIT_SUPPLY_LOW]));
    end
  end

  // Software-written registers; reserved fields stored as written, except in rate fraction and event mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routing_one_r <= `RSMR_RST_PIN_ROUTING;
      routing_two_r <= `RSMR_RST_PIN_ROUTING;
      fast_hop_r    <= `RSMR_RST_FAST_HOP;
      ref_clock_r   <= `RSMR_RST_REF_CLOCK;
      amp_boost_r   <= `RSMR_RST_AMP_BOOST;
      cal_temp_r    <= `RSMR_RST_CAL_TEMPERATURE;
      rate_frac_r   <= `RSMR_RST_BITRATE_FRACTION;
      ev_mask_r     <= {`RSMR_EV_COUNT{1'b0}};
    end else begin
      if (wr_go) begin
        case (idx)
          `RSMR_IDX_PIN_ROUTING_ONE:  routing_one_r <= pwdata[7:0];
          `RSMR_IDX_PIN_ROUTING_TWO:  routing_two_r <= pwdata[7:0];
          `RSMR_IDX_FAST_HOP_CONTROL: fast_hop_r    <= pwdata[7:0];
          `RSMR_IDX_REF_CLOCK_SELECT: ref_clock_r   <= pwdata[7:0];
          `RSMR_IDX_AMP_BOOST_OPTION: amp_boost_r   <= pwdata[7:0];
          `RSMR_IDX_BITRATE_FRACTION: rate_frac_r   <= pwdata[3:0];
          `RSMR_IDX_EVENT_MASK:       ev_mask_r     <= pwdata[`RSMR_EV_COUNT-1:0];
          default: ;
        endcase
      end
      // Calibration capture wins over a simultaneous software write
      if (cal_done) begin
        cal_temp_r <= live_temperature_reading;
      end else if (wr_go && idx == `RSMR_IDX_CAL_TEMPERATURE) begin
        cal_temp_r <= pwdata[7:0];
      end
    end
  end

  // Sticky event status, write one to clear, set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_status_r <= {`RSMR_EV_COUNT{1'b0}};
      irq         <= 1'b0;
    end else begin
      if (wr_go && idx == `RSMR_IDX_EVENT_STATUS) begin
        ev_status_r <= ev_set | (ev_status_r & ~pwdata[`RSMR_EV_COUNT-1:0]);
      end else begin
        ev_status_r <= ev_set | ev_status_r;
      end
      irq <= |(ev_status_r & ev_mask_r);
    end
  end

  // Routed event pins
  genvar p;
  generate
    for (p = 0; p < 6; p = p + 1) begin : g_pin
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          event_pin[p] <= 1'b0;
        end else begin
          event_pin[p] <= pin_source(routing[11-2*p -: 2], done_ev, level,
                                     routed_ev, supply_low_r);
        end
      end
    end
  endgenerate

  // Radio controls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_prev_r               <= `RSMR_MODE_SLEEP;
      freq_apply                <= 1'b0;
      external_reference_select <= 1'b0;
      amplifier_boost_field     <= 3'h4;
      boost_20dbm_active        <= 1'b0;
      rate_divider_fraction     <= 4'h0;
      rate_fraction_active      <= 1'b0;
    end else begin
      mode_prev_r <= op_mode;
      // Quick hop skips waiting for the next synth mode request
      if (fast_hop_r[`RSMR_BIT_QUICK_HOP]) begin
        freq_apply <= carrier_freq_low_byte_wr;
      end else begin
        freq_apply <= synth_in;
      end
      external_reference_select <= ref_clock_r[`RSMR_BIT_EXT_REFERENCE];
      amplifier_boost_field     <= amp_boost_r[2:0];
      boost_20dbm_active        <= (amp_boost_r[2:0] == `RSMR_BOOST_MAX) &&
                                   (tx_power_setting == 4'hf);
      rate_divider_fraction     <= rate_frac_r;
      rate_fraction_active      <= fsk_mode & (rate_frac_r != 4'h0);
    end
  end

  // Read mux; unmapped indices read zero with an error
  always @* begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    case (idx)
      `RSMR_IDX_IRQ_STATUS_TWO:   rdata[7:0] = flags;
      `RSMR_IDX_PIN_ROUTING_ONE:  rdata[7:0] = routing_one_r;
      `RSMR_IDX_PIN_ROUTING_TWO:  rdata[7:0] = routing_two_r;
      `RSMR_IDX_CHIP_REVISION:    rdata[7:0] = REV_CODE;
      `RSMR_IDX_FAST_HOP_CONTROL: rdata[7:0] = fast_hop_r;
      `RSMR_IDX_REF_CLOCK_SELECT: rdata[7:0] = ref_clock_r;
      `RSMR_IDX_AMP_BOOST_OPTION: rdata[7:0] = amp_boost_r;
      `RSMR_IDX_CAL_TEMPERATURE:  rdata[7:0] = cal_temp_r;
      `RSMR_IDX_BITRATE_FRACTION: rdata[3:0] = rate_frac_r;
      `RSMR_IDX_EVENT_STATUS:     rdata[`RSMR_EV_COUNT-1:0] = ev_status_r;
      `RSMR_IDX_EVENT_MASK:       rdata[`RSMR_EV_COUNT-1:0] = ev_mask_r;
      default:                    hit = 1'b0;
    endcase
    if (paddr[ADDR_W-1:10] != {(ADDR_W-10){1'b0}}) begin
      hit = 1'b0;
    end
  end

  // One wait-free access phase; data sampled at setup so flags read then
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup) begin
        prdata <= (pwrite | ~hit) ? 32'h0000_0000 : rdata;
      end
    end
  end

endmodule

// ===== sim/rsmr_regs_props.sv
/* Checker of the status and misc register bank, bound to its ports.
   Assumes zero-wait APB answers and one-cycle strobes on pclk. */
`timescale 1ns/1ps
module rsmr_regs_chk #(
  parameter ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [2:0]        op_mode,
  input wire logic              carrier_freq_low_byte_wr,
  input wire logic [3:0]        tx_power_setting,
  input wire logic              fsk_mode,
  input wire logic              queue_flush,
  input wire logic              freq_apply,
  input wire logic              external_reference_select,
  input wire logic [2:0]        amplifier_boost_field,
  input wire logic              boost_20dbm_active,
  input wire logic [3:0]        rate_divider_fraction,
  input wire logic              rate_fraction_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wdone = psel & penable & pready & pwrite & pstrb[0];
  reg  hop_r;
  // Shadow of the quick hop bit, needed to know which apply cause counts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) hop_r <= 1'b0;
    else if (wdone && paddr == 12'h110) hop_r <= pwdata[7];
  end
  AST_SETUP_ANSWER: assert property (psel && !penable |=> psel && penable && pready)
    else $error("setup not answered in next cycle");
  AST_FLUSH_PULSE: assert property (
    wdone && paddr == 12'h0fc && pwdata[4] |=> ##[0:1] (queue_flush ##1 !queue_flush))
    else $error("flush pulse missing after overrun clear");
  AST_HOP_APPLY: assert property (carrier_freq_low_byte_wr && hop_r |=> freq_apply)
    else $error("quick hop did not apply frequency");
  AST_SYNTH_APPLY: assert property (
    !hop_r && $changed(op_mode) && (op_mode == 3'h2 || op_mode == 3'h4) |=> freq_apply)
    else $error("synth mode entry did not apply frequency");
  AST_REF_SELECT: assert property (
    wdone && paddr == 12'h12c |=> ##1 external_reference_select == $past(pwdata[4], 2))
    else $error("reference select not taken from write");
  AST_BOOST_WRITE: assert property (
    wdone && paddr == 12'h134 |=> ##1 amplifier_boost_field == $past(pwdata[2:0], 2))
    else $error("boost field not taken from write");
  AST_BOOST_RESET: assert property ($rose(presetn) |-> amplifier_boost_field == 3'h4)
    else $error("boost field reset value wrong");
  AST_BOOST_20DBM: assert property (
    (amplifier_boost_field == 3'h7 && tx_power_setting == 4'hf)[*2] |-> boost_20dbm_active)
    else $error("high power mode not active");
  AST_FRAC_WRITE: assert property (
    wdone && paddr == 12'h174 |=> ##1 rate_divider_fraction == $past(pwdata[3:0], 2))
    else $error("rate fraction not taken from write");
  AST_FRAC_IDLE: assert property (
    (rate_divider_fraction == 4'h0)[*2] |-> !rate_fraction_active)
    else $error("fraction active while zero");
  cover property (wdone && paddr == 12'h0fc && pwdata[4]);
  cover property (freq_apply);
  cover property (boost_20dbm_active && fsk_mode);
  cover property (pslverr);
endmodule
bind rsmr_regs rsmr_regs_chk #(.ADDR_W(ADDR_W)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .op_mode(op_mode), .carrier_freq_low_byte_wr(carrier_freq_low_byte_wr),
  .tx_power_setting(tx_power_setting), .fsk_mode(fsk_mode), .queue_flush(queue_flush),
  .freq_apply(freq_apply), .external_reference_select(external_reference_select),
  .amplifier_boost_field(amplifier_boost_field), .boost_20dbm_active(boost_20dbm_active),
  .rate_divider_fraction(rate_divider_fraction), .rate_fraction_active(rate_fraction_active));

// ===== sim/rsmr_regs_test.sv
/* Self-checking bench of the status and misc register bank.
   Assumes the bank is the only APB slave and runs on a 25 MHz pclk. */
`timescale 1ns/1ps
module rsmr_regs_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, tx_power_setting, rate_divider_fraction;
  logic [2:0]  op_mode, amplifier_boost_field;
  logic [5:0]  queue_threshold, event_pin, pls;
  logic [7:0]  live_temperature_reading;
  logic        rx_checksum_pass, checksum_enable, checksum_autoclear_disable;
  logic        supply_below_async, rssi_event, preamble_found_event, fsk_mode;
  logic        queue_flush, freq_apply, external_reference_select, boost_20dbm_active;
  logic        rate_fraction_active;
  int          errors = 0, checked = 0, seed = 13799, i, c;
  logic [7:0]  ridx [11] = '{8'h3f, 8'h40, 8'h41, 8'h42, 8'h44, 8'h4b, 8'h4d, 8'h5b, 8'h5d,
                             8'h7c, 8'h7d};
  logic [7:0]  rrst [11] = '{8'h40, 8'h00, 8'h00, 8'h5a, 8'h2d, 8'h09, 8'h84, 8'h00, 8'h00,
                             8'h00, 8'h00};
  logic [7:0]  fmsk [11] = '{8'h00, 8'hff, 8'hf1, 8'h00, 8'h80, 8'h10, 8'h07, 8'hff, 8'h0f,
                             8'h00, 8'h00};
  logic [7:0]  v [11];

  rsmr_regs #(.ADDR_W(12), .THRESH_W(6), .REV_CODE(8'h5a)) i_dut ( // Revision arbitrary
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_mode(op_mode), .queue_push(pls[0]), .queue_pop(pls[1]),
    .queue_threshold(queue_threshold), .tx_packet_end(pls[2]), .rx_last_byte(pls[3]),
    .rx_checksum_pass(rx_checksum_pass), .checksum_enable(checksum_enable),
    .checksum_autoclear_disable(checksum_autoclear_disable),
    .supply_below_async(supply_below_async), .rssi_event(rssi_event),
    .preamble_found_event(preamble_found_event), .carrier_freq_low_byte_wr(pls[4]),
    .tx_power_setting(tx_power_setting), .fsk_mode(fsk_mode), .cal_done(pls[5]),
    .live_temperature_reading(live_temperature_reading), .queue_flush(queue_flush),
    .event_pin(event_pin), .freq_apply(freq_apply),
    .external_reference_select(external_reference_select),
    .amplifier_boost_field(amplifier_boost_field), .boost_20dbm_active(boost_20dbm_active),
    .rate_divider_fraction(rate_divider_fraction), .rate_fraction_active(rate_fraction_active),
    .irq(irq));

  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Whole transfer held until pready is seen; bounded so a dead slave cannot hang
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1;
    // Mid-cycle look: pready seen here is what the next rising edge samples
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 20) chk(0, 1);
    rdat = prdata;
    last_err = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic pulse(input int k);
    @(posedge pclk);
    pls[k] <= 1;
    @(posedge pclk);
    pls <= 6'h00;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // Count 67 stands for a push into a full queue
  function automatic logic [31:0] exp_q(input int n, input int t);
    return {24'h00_0000, n >= 66, n == 0, n > t, n > 66, 4'h0};
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run is some 550 cycles; limit of 10000 cycles leaves ample margin
  initial begin
    #400_000;
    errors++;
    print_verdict;
  end

  initial begin
    {presetn, psel, penable, pwrite, pls, rx_checksum_pass, supply_below_async} = '0;
    {paddr, pwdata, queue_threshold, live_temperature_reading, preamble_found_event} = '0;
    {pstrb, tx_power_setting, op_mode, checksum_enable, rssi_event, fsk_mode} = 14'h3fcf;
    checksum_autoclear_disable = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 11; i++) begin
      apb(0, ridx[i], 8'h00);
      chk(rdat, rrst[i]);
    end
    apb(1, 8'h42, 8'hff);
    apb(0, 8'h42, 8'h00);
    chk(rdat, 8'h5a);
    apb(0, 8'h43, 8'h00);
    chk(last_err, 1);
    chk(rdat, 32'h0000_0000);
    done("reset");
    queue_threshold <= 6'($random(seed));
    for (i = 1; i < 68; i++) begin
      pulse(0);
      apb(0, 8'h3f, 8'h00);
      chk(rdat & 32'h0000_00f0, exp_q(i, queue_threshold));
    end
    apb(1, 8'h3f, 8'h00);
    apb(0, 8'h3f, 8'h00);
    chk(rdat & 32'h0000_00f0, exp_q(67, queue_threshold));
    apb(1, 8'h3f, 8'h10);
    apb(0, 8'h3f, 8'h00);
    chk(rdat & 32'h0000_00f0, exp_q(0, queue_threshold));
    done("queue");
    op_mode <= 3'h3;
    pulse(2);
    apb(0, 8'h3f, 8'h00);
    chk(rdat & 32'h0000_0008, 32'h0000_0008);
    op_mode <= 3'h1;
    apb(0, 8'h3f, 8'h00);
    chk(rdat & 32'h0000_0008, 32'h0000_0000);
    op_mode <= 3'h5;
    queue_threshold <= 6'h3f;
    pulse(0);
    pulse(3);
    apb(0, 8'h3f, 8'h00);
    chk(rdat & 32'h0000_0046, 32'h0000_0000);
    rx_checksum_pass <= 1;
    pulse(3);
    apb(0, 8'h3f, 8'h00);
    chk(rdat & 32'h0000_0046, 32'h0000_0006);
    pulse(1);
    apb(0, 8'h3f, 8'h00);
    chk(rdat & 32'h0000_0046, 32'h0000_0040);
    done("packet");
    apb(1, 8'h7c, 8'h1f);
    supply_below_async <= 1;
    tick(4);
    supply_below_async <= 0;
    tick(4);
    apb(1, 8'h3f, 8'h00);
    apb(0, 8'h3f, 8'h00);
    chk(rdat & 32'h0000_0001, 32'h0000_0001);
    chk(irq, 0);
    apb(0, 8'h7c, 8'h00);
    chk(rdat, 32'h0000_0010);
    apb(1, 8'h7d, 8'h10);
    tick(2);
    chk(irq, 1);
    apb(1, 8'h7c, 8'h10);
    tick(2);
    chk(irq, 0);
    apb(1, 8'h3f, 8'h01);
    apb(0, 8'h3f, 8'h00);
    chk(rdat & 32'h0000_0001, 32'h0000_0000);
    done("supply");
    for (c = 0; c < 2; c++) begin
      apb(1, 8'h40, 8'haa);
      apb(1, 8'h41, {7'h50, c[0]});
      tick(2);
      chk(event_pin, c ? 6'h00 : 6'h3f);
    end
    for (i = 1; i < 9; i++) begin
      v[i] = (8'($random(seed)) & fmsk[i]) | rrst[i];
      apb(1, ridx[i], v[i]);
      apb(0, ridx[i], 8'h00);
      chk(rdat, v[i]);
    end
    chk({external_reference_select, amplifier_boost_field, rate_divider_fraction},
        {v[5][4], v[6][2:0], v[8][3:0]});
    chk(rate_fraction_active, v[8][3:0] != 4'h0);
    apb(1, 8'h4d, 8'h87);
    tick(2);
    chk(boost_20dbm_active, 1);
    apb(1, 8'h44, 8'had);
    pulse(4);
    @(negedge pclk);
    chk(freq_apply, 1);
    apb(1, 8'h44, 8'h2d);
    op_mode <= 3'h2;
    @(posedge pclk);
    @(negedge pclk);
    chk(freq_apply, 1);
    @(posedge pclk);
    live_temperature_reading <= 8'($random(seed));
    pulse(5);
    apb(0, 8'h5b, 8'h00);
    chk(rdat, live_temperature_reading);
    done("controls");
    print_verdict;
  end
endmodule
